/* rtl/clockgen_ctrl_regs.sv */
// General control register bank of the clock generator.
// Assumes a serial front end issuing single-cycle read and write strobes.
module clockgen_ctrl_regs
    import clockgen_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk_in,
    input  wire logic              srst_in,
    // Register port
    input  wire logic [REG_AW-1:0] reg_addr_in,
    input  wire logic              reg_wr_in,
    input  wire logic [REG_DW-1:0] reg_wdata_in,
    input  wire logic              reg_rd_in,
    output logic      [REG_DW-1:0] reg_rdata_out,
    output logic                   reg_rvalid_out,
    // Page load
    input  wire logic              page_load_in,
    input  wire logic              page_addr_bit_in,
    output logic                   target_address_low_bit_out,
    // General pins
    input  wire logic              pin_zero_in,
    input  wire logic              pin_one_in,
    input  wire logic              pin_four_in,
    input  wire logic [2:0]        pin_status_in,
    output clockgen_ctrl_pkg::pin_drive_t pin_zero_out,
    output clockgen_ctrl_pkg::pin_drive_t pin_one_out,
    output clockgen_ctrl_pkg::pin_drive_t pin_four_out,
    output logic      [FUNC_W-1:0] pin_zero_out_sel_out,
    output logic      [FUNC_W-1:0] pin_one_out_sel_out,
    output logic      [FUNC_W-1:0] pin_four_out_sel_out,
    // Reference mux
    input  wire logic              ref_sel_pin_in,
    output logic                   ref_select_out,
    // Analog and PLL control
    output logic                   zero_delay_mode_out,
    output logic                   external_feedback_out,
    output logic                   lockdet_reset_out,
    output logic                   analog_powerdown_out,
    output logic                   pin_mode_out,
    output clockgen_ctrl_pkg::oe_t output_enable_out,
    // Divider sync and logic reset
    output logic                   sync_pulse_out,
    output logic                   logic_reset_out,
    // Sequencer
    input  wire logic              config_done_in,
    input  wire logic              cal_done_in,
    output logic                   config_run_out,
    output logic                   cal_run_out,
    output logic                   cal_keep_codes_out,
    output logic                   seq_done_out
);
    import clockgen_ctrl_pkg::*;

    // Stored registers; self-clearing bits live in their own strobes
    logic [REG_DW-1:0] gen_ff;
    logic [REG_DW-1:0] nxt_gen;
    logic [REG_DW-1:0] refsel_ff;
    logic [REG_DW-1:0] outsel_ff;
    logic              sync_ff;
    logic              recal_ff;
    logic              swrst_ff;
    logic              pin0_ff;
    logic [REG_DW-1:0] rdata_ff;
    logic              rvalid_ff;

    // Address decode
    wire logic hit_gen    = (reg_addr_in == OFS_GENERAL_CONTROL);
    wire logic hit_refsel = (reg_addr_in == OFS_REF_PIN_SEL);
    wire logic hit_outsel = (reg_addr_in == OFS_PIN_OUT_SEL);
    wire logic wr_gen     = reg_wr_in && hit_gen;
    wire logic wr_refsel  = reg_wr_in && hit_refsel;
    wire logic wr_outsel  = reg_wr_in && hit_outsel;

    // Pin zero as reset or sync input
    // Pin zero function
    wire logic pin0_is_input = !gen_ff[BIT_PIN0_DIR];
    wire logic pin0_reset_fn = pin0_is_input && !gen_ff[BIT_PIN0_FUNC];
    wire logic pin0_sync_fn  = pin0_is_input && gen_ff[BIT_PIN0_FUNC];
    wire logic pin_reset     = pin0_reset_fn && !pin_zero_in;

    wire logic regs_reset    = srst_in || (pin_reset && !gen_ff[BIT_PIN_SOFT]);

    wire logic fsm_reset     = srst_in || pin_reset || swrst_ff;

    // Sync input acts on the release edge of the pin
    wire logic pin_sync_rise = pin0_sync_fn && pin_zero_in && !pin0_ff;

    // Next general control value; strobe bits never stored
    always_comb
    begin
        nxt_gen = gen_ff;
        if (wr_gen)
            nxt_gen = reg_wdata_in;
        if (page_load_in)
            nxt_gen[BIT_ADDR_LOW] = page_addr_bit_in;
        nxt_gen[BIT_SYNC]  = 1'b0;
        nxt_gen[BIT_RECAL] = 1'b0;
        nxt_gen[BIT_SWRST] = 1'b0;
    end

    always_ff @(posedge mclk_in)
    begin
        if (regs_reset)
        begin
            gen_ff    <= RST_GENERAL_CONTROL;
            refsel_ff <= RST_REF_PIN_SEL;
            outsel_ff <= RST_PIN_OUT_SEL;
        end
        else
        begin
            gen_ff <= nxt_gen;
            if (wr_refsel)
                refsel_ff <= reg_wdata_in;
            if (wr_outsel)
                outsel_ff <= reg_wdata_in;
        end
    end

    // Strobes last exactly one cycle after the accepting write
    always_ff @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            sync_ff  <= 1'b0;
            recal_ff <= 1'b0;
            swrst_ff <= 1'b0;
            pin0_ff  <= 1'b1;
        end
        else
        begin
            sync_ff  <= wr_gen && reg_wdata_in[BIT_SYNC];
            recal_ff <= wr_gen && reg_wdata_in[BIT_RECAL];
            swrst_ff <= wr_gen && reg_wdata_in[BIT_SWRST];
            pin0_ff  <= pin_zero_in;
        end
    end

    // Read path
    wire logic [REG_DW-1:0] gen_view = gen_ff
        | (REG_DW'(sync_ff)  << BIT_SYNC)
        | (REG_DW'(recal_ff) << BIT_RECAL)
        | (REG_DW'(swrst_ff) << BIT_SWRST);
    wire logic [REG_DW-1:0] rd_mux = hit_gen    ? gen_view  :
                                     hit_refsel ? refsel_ff :
                                     hit_outsel ? outsel_ff : '0;

    always_ff @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            rdata_ff  <= '0;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rvalid_ff <= reg_rd_in;
            if (reg_rd_in)
                rdata_ff <= rd_mux;
        end
    end

    assign reg_rdata_out  = rdata_ff;
    assign reg_rvalid_out = rvalid_ff;

    assign target_address_low_bit_out = gen_ff[BIT_ADDR_LOW];

    assign pin_zero_out.oe = gen_ff[BIT_PIN0_DIR];
    assign pin_one_out.oe  = gen_ff[BIT_PIN1_DIR];
    assign pin_four_out.oe = gen_ff[BIT_PIN4_DIR];
    assign pin_zero_out.out = pin_status_in[0];
    assign pin_one_out.out  = pin_status_in[1];
    assign pin_four_out.out = pin_status_in[2];
    assign pin_zero_out_sel_out = outsel_ff[FLD_PIN0_OUT +: FUNC_W];
    assign pin_one_out_sel_out  = outsel_ff[FLD_PIN1_OUT +: FUNC_W];
    assign pin_four_out_sel_out = outsel_ff[FLD_PIN4_OUT +: FUNC_W];

    assign ref_select_out = refsel_ff[BIT_REF_SRC] ? refsel_ff[BIT_REF_OVR] : ref_sel_pin_in;

    assign zero_delay_mode_out   = gen_ff[BIT_ZDM];
    assign external_feedback_out = gen_ff[BIT_ZDM] && gen_ff[BIT_FB_SEL];

    assign lockdet_reset_out = gen_ff[BIT_LOCKDET_RST];

    assign analog_powerdown_out = gen_ff[BIT_POWERDOWN];

    assign pin_mode_out = gen_ff[BIT_MODE];

    assign sync_pulse_out  = sync_ff || pin_sync_rise;
    assign logic_reset_out = fsm_reset;

    // Pins only steer enables in pin mode and as inputs
    // Pin-mode enables
    wire logic pin1_active = gen_ff[BIT_MODE] && !gen_ff[BIT_PIN1_DIR];
    wire logic pin4_active = gen_ff[BIT_MODE] && !gen_ff[BIT_PIN4_DIR];

    clockgen_pin_oe u_pin_oe (
        .pin1_func_in   (refsel_ff[FLD_PIN1_FUNC +: FUNC_W]),
        .pin4_func_in   (refsel_ff[FLD_PIN4_FUNC +: FUNC_W]),
        .pin1_level_in  (pin_one_in),
        .pin4_level_in  (pin_four_in),
        .pin1_active_in (pin1_active),
        .pin4_active_in (pin4_active),
        .oe_out         (output_enable_out)
    );

    clockgen_seq u_seq (
        .mclk_in            (mclk_in),
        .fsm_rst_in         (fsm_reset),
        .recal_in           (recal_ff),
        .config_done_in     (config_done_in),
        .cal_done_in        (cal_done_in),
        .config_run_out     (config_run_out),
        .cal_run_out        (cal_run_out),
        .cal_keep_codes_out (cal_keep_codes_out),
        .seq_done_out       (seq_done_out)
    );

endmodule

/* rtl/clockgen_ctrl_pkg.sv */
// Package for the clock generator general control register bank.
// Assumes a 16-bit register port driven by the serial control front end.
package clockgen_ctrl_pkg;

    // Register port geometry
    localparam int REG_AW = 8;
    localparam int REG_DW = 16;

    // Register offsets
    localparam logic [REG_AW-1:0] OFS_GENERAL_CONTROL = 8'h00;
    localparam logic [REG_AW-1:0] OFS_REF_PIN_SEL     = 8'h01;
    localparam logic [REG_AW-1:0] OFS_PIN_OUT_SEL     = 8'h02;

    // Reset values
    localparam logic [REG_DW-1:0] RST_GENERAL_CONTROL = 16'h0000;
    localparam logic [REG_DW-1:0] RST_REF_PIN_SEL     = 16'h6A32;
    localparam logic [REG_DW-1:0] RST_PIN_OUT_SEL     = 16'h0053;

    // General control field positions
    localparam int BIT_ADDR_LOW    = 15;
    localparam int BIT_PIN0_FUNC   = 14;
    localparam int BIT_PIN4_DIR    = 13;
    localparam int BIT_PIN1_DIR    = 12;
    localparam int BIT_PIN0_DIR    = 11;
    localparam int BIT_FB_SEL      = 10;
    localparam int BIT_ZDM         = 8;
    localparam int BIT_LOCKDET_RST = 6;
    localparam int BIT_SYNC        = 5;
    localparam int BIT_RECAL       = 4;
    localparam int BIT_PIN_SOFT    = 3;
    localparam int BIT_SWRST       = 2;
    localparam int BIT_POWERDOWN   = 1;
    localparam int BIT_MODE        = 0;

    // Reference and pin input select field positions
    localparam int BIT_REF_SRC     = 9;
    localparam int BIT_REF_OVR     = 8;
    localparam int FUNC_W          = 4;
    localparam int FLD_PIN4_FUNC   = 4;
    localparam int FLD_PIN1_FUNC   = 0;

    // Pin output select field positions
    localparam int FLD_PIN0_OUT    = 8;
    localparam int FLD_PIN4_OUT    = 4;
    localparam int FLD_PIN1_OUT    = 0;

    // Input function codes; channel n uses FUNC_CH1_OE + n - 1
    localparam logic [FUNC_W-1:0] FUNC_GLOBAL_OE = 4'h2;
    localparam logic [FUNC_W-1:0] FUNC_CH1_OE    = 4'h4;
    localparam int                NUM_CH         = 4;

    // Output enables recovered from the general pins
    typedef struct packed {
        logic              global_en;
        logic [NUM_CH-1:0] channel_en;
    } oe_t;

    // Drive of one general pin
    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;

    // Start-up sequencer
    typedef enum logic [1:0] {
        SEQ_CONFIG = 2'b00,
        SEQ_CAL    = 2'b01,
        SEQ_DONE   = 2'b11
    } seq_state_t;

endpackage

/* rtl/clockgen_seq.sv */
// Configuration then calibration sequencer.
// Assumes done inputs are synchronous single-cycle or level indications.
module clockgen_seq
    import clockgen_ctrl_pkg::*;
(
    // Clock and state machine reset
    input  wire logic mclk_in,
    input  wire logic fsm_rst_in,
    // Control
    input  wire logic recal_in,
    input  wire logic config_done_in,
    input  wire logic cal_done_in,
    // Status
    output logic      config_run_out,
    output logic      cal_run_out,
    output logic      cal_keep_codes_out,
    output logic      seq_done_out
);
    import clockgen_ctrl_pkg::*;

    seq_state_t state_ff;
    seq_state_t nxt_state;
    logic       keep_ff;
    logic       nxt_keep;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_keep  = keep_ff;
        case (state_ff)
            SEQ_CONFIG:
            begin
                nxt_keep = 1'b0;
                if (config_done_in)
                    nxt_state = SEQ_CAL;
            end
            SEQ_CAL:
            begin
                if (cal_done_in)
                    nxt_state = SEQ_DONE;
            end
            SEQ_DONE:
            begin
                // Recalibration keeps present capacitor and cross codes
                if (recal_in)
                begin
                    nxt_state = SEQ_CAL;
                    nxt_keep  = 1'b1;
                end
            end
            default:
            begin
                nxt_state = SEQ_CONFIG;
                nxt_keep  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_in)
    begin
        if (fsm_rst_in)
        begin
            state_ff <= SEQ_CONFIG;
            keep_ff  <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            keep_ff  <= nxt_keep;
        end
    end

    assign config_run_out     = (state_ff == SEQ_CONFIG);
    assign cal_run_out        = (state_ff == SEQ_CAL);
    assign cal_keep_codes_out = keep_ff;
    assign seq_done_out       = (state_ff == SEQ_DONE);

endmodule

/* rtl/clockgen_pin_oe.sv */
// Output enable recovery from the input functions of general pins 1 and 4.
// Assumes pin levels are already synchronous to the clock.
module clockgen_pin_oe
    import clockgen_ctrl_pkg::*;
(
    // Function codes
    input  wire logic [FUNC_W-1:0] pin1_func_in,
    input  wire logic [FUNC_W-1:0] pin4_func_in,
    // Pin levels and their qualifiers
    input  wire logic              pin1_level_in,
    input  wire logic              pin4_level_in,
    input  wire logic              pin1_active_in,
    input  wire logic              pin4_active_in,
    // Enables
    output clockgen_ctrl_pkg::oe_t oe_out
);
    import clockgen_ctrl_pkg::*;

    // An enable not claimed by an active pin stays on
    wire logic glob1 = pin1_active_in && (pin1_func_in == FUNC_GLOBAL_OE);
    wire logic glob4 = pin4_active_in && (pin4_func_in == FUNC_GLOBAL_OE);

    assign oe_out.global_en = (!glob1 || pin1_level_in) && (!glob4 || pin4_level_in);

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch = ch + 1)
        begin : g_ch
            localparam logic [FUNC_W-1:0] CODE = FUNC_CH1_OE + FUNC_W'(ch);
            wire logic hit1 = pin1_active_in && (pin1_func_in == CODE);
            wire logic hit4 = pin4_active_in && (pin4_func_in == CODE);
            assign oe_out.channel_en[ch] = (!hit1 || pin1_level_in) && (!hit4 || pin4_level_in);
        end
    endgenerate

endmodule

/* verif/seq_partner.sv */
// Model of the calibration and configuration engines beside the sequencer.
// Assumes run levels from the sequencer; answers each phase after DELAY cycles.
module seq_partner #(
    parameter int DELAY = 3
) (
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic srst_in,
    // Phase requests
    input  wire logic config_run_in,
    input  wire logic cal_run_in,
    // Phase completions
    output logic      config_done_out,
    output logic      cal_done_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] wait_ff;
    wire        busy = config_run_in | cal_run_in;
    wire        hit  = wait_ff == 8'(DELAY);

    assign config_done_out = config_run_in & hit;
    assign cal_done_out    = cal_run_in & hit;

    // Restarts its count after each answer, so a restart mid-phase is answered early, not lost
    always_ff @(posedge mclk_in)
    begin
        wait_ff <= (srst_in | ~busy | hit) ? 8'h00 : wait_ff + 8'h01;
    end
endmodule

/* verif/clockgen_ctrl_regs_monitor.sv */
// Concurrent checks on the general control register bank ports.
// Assumes register writes never coincide with a pin reset or page load.
module clockgen_ctrl_regs_monitor
    import clockgen_ctrl_pkg::*;
(
    // Watched ports
    input wire logic              mclk_in,
    input wire logic              srst_in,
    input wire logic [REG_AW-1:0] reg_addr_in,
    input wire logic              reg_wr_in,
    input wire logic [REG_DW-1:0] reg_wdata_in,
    input wire logic              reg_rd_in,
    input wire logic              reg_rvalid_out,
    input wire logic              page_load_in,
    input wire logic              page_addr_bit_in,
    input wire logic              target_address_low_bit_out,
    input wire pin_drive_t        pin_four_out,
    input wire logic              ref_sel_pin_in,
    input wire logic              ref_select_out,
    input wire logic              zero_delay_mode_out,
    input wire logic              external_feedback_out,
    input wire logic              lockdet_reset_out,
    input wire logic              analog_powerdown_out,
    input wire logic              sync_pulse_out,
    input wire logic              logic_reset_out,
    input wire logic              config_run_out,
    input wire logic              cal_run_out,
    input wire logic              cal_keep_codes_out,
    input wire logic              seq_done_out
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);

    wire gen_wr = reg_wr_in & (reg_addr_in == OFS_GENERAL_CONTROL);
    wire ref_wr = reg_wr_in & (reg_addr_in == OFS_REF_PIN_SEL);

    sequence s_soft_reset;
        logic_reset_out ##1 config_run_out;
    endsequence
    sequence s_recal;
        ##1 (cal_run_out && cal_keep_codes_out);
    endsequence

    a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read not answered next cycle");
    a_page_bit_load: assert property (page_load_in |=>
        target_address_low_bit_out == $past(page_addr_bit_in))
        else $error("page load bit not taken");
    a_pin_dir_oe: assert property (gen_wr |=>
        pin_four_out.oe == $past(reg_wdata_in[13]))
        else $error("pin four direction wrong");
    a_zdm_feedback: assert property (gen_wr |=>
        external_feedback_out == ($past(reg_wdata_in[8]) & $past(reg_wdata_in[10])))
        else $error("feedback select wrong");
    a_lockdet_level: assert property (gen_wr |=>
        lockdet_reset_out == $past(reg_wdata_in[6]))
        else $error("lock detector reset wrong");
    a_sync_strobe: assert property (gen_wr && reg_wdata_in[5] |=> sync_pulse_out)
        else $error("sync pulse missing");
    a_recal_keep: assert property (
        gen_wr && reg_wdata_in[4] && !reg_wdata_in[2] && seq_done_out |=> s_recal)
        else $error("recalibration not started");
    a_soft_reset: assert property (gen_wr && reg_wdata_in[2] |=> s_soft_reset)
        else $error("soft reset sequence wrong");
    a_powerdown_lvl: assert property (gen_wr |=>
        analog_powerdown_out == $past(reg_wdata_in[1]))
        else $error("power down level wrong");
    a_ref_mux_sel: assert property (ref_wr |=>
        ref_select_out == ($past(reg_wdata_in[9]) ? $past(reg_wdata_in[8]) : ref_sel_pin_in))
        else $error("reference select wrong");
endmodule

bind clockgen_ctrl_regs clockgen_ctrl_regs_monitor mon_u (
    .mclk_in, .srst_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in,
    .reg_rvalid_out, .page_load_in, .page_addr_bit_in, .target_address_low_bit_out,
    .pin_four_out, .ref_sel_pin_in, .ref_select_out, .zero_delay_mode_out,
    .external_feedback_out, .lockdet_reset_out, .analog_powerdown_out,
    .sync_pulse_out, .logic_reset_out, .config_run_out, .cal_run_out,
    .cal_keep_codes_out, .seq_done_out
);

/* verif/clockgen_ctrl_regs_test.sv */
// Directed bench for the general control register bank.
// Assumes the sequencer partner model answers each phase in a few cycles.
module clockgen_ctrl_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import clockgen_ctrl_pkg::*;

    logic              mclk_in = 1'b0, srst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic              page_load_in = 1'b0, page_addr_bit_in = 1'b0, ref_sel_pin_in = 1'b0;
    logic              pin_zero_in = 1'b1, pin_one_in = 1'b1, pin_four_in = 1'b1;
    logic [REG_AW-1:0] reg_addr_in = '0;
    logic [REG_DW-1:0] reg_wdata_in = '0, reg_rdata_out;
    logic [2:0]        pin_status_in = '0;
    logic              reg_rvalid_out, target_address_low_bit_out, ref_select_out;
    pin_drive_t        pin_zero_out, pin_one_out, pin_four_out;
    logic [FUNC_W-1:0] pin_zero_out_sel_out, pin_one_out_sel_out, pin_four_out_sel_out;
    logic              zero_delay_mode_out, external_feedback_out, lockdet_reset_out;
    logic              analog_powerdown_out, pin_mode_out, sync_pulse_out, logic_reset_out;
    oe_t               output_enable_out;
    logic              config_done_in, cal_done_in, config_run_out, cal_run_out;
    logic              cal_keep_codes_out, seq_done_out;
    logic [4:0]        exp_oe;
    logic [3:0]        code;
    int                error_cnt = 0, checks_done = 0, cyc = 0, i;

    clockgen_ctrl_regs dut_u (.*);
    seq_partner #(.DELAY(3)) part_u (.mclk_in(mclk_in), .srst_in(srst_in),
        .config_run_in(config_run_out), .cal_run_in(cal_run_out),
        .config_done_out(config_done_in), .cal_done_out(cal_done_in));

    always #20 mclk_in = ~mclk_in;

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Returns at the falling edge of the cycle after the write is taken
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a; reg_wdata_in <= d; reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
        @(negedge mclk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge mclk_in);
        reg_addr_in <= a; reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        @(negedge mclk_in);
        chk(reg_rvalid_out, 16'h0001);
        chk(reg_rdata_out, e);
    endtask
    task automatic wait_done();
        for (i = 0; i < 40 && seq_done_out !== 1'b1; i++) @(negedge mclk_in);
        chk(seq_done_out, 16'h0001);
    endtask
    task automatic pin_pulse_low();
        @(posedge mclk_in) pin_zero_in <= 1'b0;
        @(posedge mclk_in);
        @(negedge mclk_in) chk(config_run_out, 16'h0001);
        @(posedge mclk_in) pin_zero_in <= 1'b1;
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // The whole run needs well under a thousand cycles
    always @(posedge mclk_in)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (16) @(posedge mclk_in);
        srst_in <= 1'b0;
        rd(8'h00, RST_GENERAL_CONTROL);
        rd(8'h01, 16'h6A32);
        rd(8'h02, 16'h0053);
        wr(8'h03, 16'hFFFF);
        rd(8'h03, 16'h0000);
        chk({pin_zero_out_sel_out, pin_four_out_sel_out, pin_one_out_sel_out}, 16'h0053);
        @(posedge mclk_in) {page_load_in, page_addr_bit_in} <= 2'b11;
        @(posedge mclk_in) page_load_in <= 1'b0;
        @(negedge mclk_in) chk(target_address_low_bit_out, 16'h0001);
        rd(8'h00, 16'h8000);
        @(posedge mclk_in) pin_status_in <= 3'b101;
        wr(8'h00, 16'h3D4B);
        chk({pin_four_out.oe, pin_one_out.oe, pin_zero_out.oe}, 16'h0007);
        chk({pin_four_out.out, pin_one_out.out, pin_zero_out.out}, 16'h0005);
        chk({zero_delay_mode_out, external_feedback_out, lockdet_reset_out,
             analog_powerdown_out, pin_mode_out}, 16'h001F);
        rd(8'h00, 16'h3D4B);
        wr(8'h00, 16'h0400);
        chk({zero_delay_mode_out, external_feedback_out}, 16'h0000);
        wr(8'h02, 16'h0ABC);
        chk({pin_zero_out_sel_out, pin_four_out_sel_out, pin_one_out_sel_out}, 16'h0ABC);
        wr(8'h00, 16'h0020);
        chk(sync_pulse_out, 16'h0001);
        @(negedge mclk_in) chk(sync_pulse_out, 16'h0000);
        rd(8'h00, 16'h0000);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge mclk_in) ref_sel_pin_in <= ~k[0];
            wr(8'h01, {6'h1A, k[1:0], 8'h32});
            chk(ref_select_out, {k[1] ? k[0] : ~k[0]});
        end
        wr(8'h00, 16'h0001);
        @(posedge mclk_in) {pin_one_in, pin_four_in} <= 2'b00;
        // Stimulus never gives both pins one function
        for (int k = 0; k < 5; k++)
        begin
            code = (k == 0) ? FUNC_GLOBAL_OE : FUNC_CH1_OE + 4'(k - 1);
            exp_oe = (k == 0) ? 5'h0F : {1'b1, ~(4'h1 << (k - 1))};
            wr(8'h01, {6'h1A, 2'b00, code, 4'h0});
            chk(output_enable_out, exp_oe);
            wr(8'h01, {6'h1A, 2'b00, 4'h0, code});
            chk(output_enable_out, exp_oe);
        end
        wr(8'h00, 16'h0000);
        chk(output_enable_out, 16'h001F);
        @(posedge mclk_in) {pin_one_in, pin_four_in} <= 2'b11;
        wr(8'h00, 16'h4000);
        @(posedge mclk_in) pin_zero_in <= 1'b0;
        @(posedge mclk_in) pin_zero_in <= 1'b1;
        @(negedge mclk_in) chk(sync_pulse_out, 16'h0001);
        @(negedge mclk_in) chk(sync_pulse_out, 16'h0000);
        rd(8'h00, 16'h4000);
        wr(8'h00, 16'h0041);
        pin_pulse_low();
        rd(8'h00, 16'h0000);
        wr(8'h00, 16'h0049);
        pin_pulse_low();
        rd(8'h00, 16'h0049);
        wait_done();
        wr(8'h00, 16'h0010);
        @(negedge mclk_in) chk({cal_run_out, cal_keep_codes_out}, 16'h0003);
        wait_done();
        wr(8'h00, 16'h0045);
        chk(logic_reset_out, 16'h0001);
        @(negedge mclk_in) chk(config_run_out, 16'h0001);
        wait_done();
        rd(8'h00, 16'h0041);
        print_verdict();
    end
endmodule
